// ==== logic/tfp_pkg.sv ====
// Package for the two-wire flash programming link registers
package tfp_pkg;

	// Link register select values
	localparam logic [7:0] SEL_PART_ID_LO  = 8'h00;
	localparam logic [7:0] SEL_REVISION_LO = 8'h01;
	localparam logic [7:0] SEL_CONTROL     = 8'h02;
	localparam logic [7:0] SEL_DATA        = 8'hB4;
	localparam logic [7:0] SEL_PART_ID     = 8'hFD;
	localparam logic [7:0] SEL_REVISION    = 8'hFE;

	// Reset values
	localparam logic [7:0] RST_SELECT  = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_DATA    = 8'h00;

	// Unlock codes, in order
	localparam logic [7:0] UNLOCK_FIRST  = 8'h02;
	localparam logic [7:0] UNLOCK_SECOND = 8'h01;

	// Flash command codes
	localparam logic [7:0] CMD_BLOCK_READ  = 8'h06;
	localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
	localparam logic [7:0] CMD_PAGE_ERASE  = 8'h08;
	localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;

	// Link instruction codes, two bits sent first bit LSB
	localparam logic [1:0] INS_DATA_READ  = 2'h0;
	localparam logic [1:0] INS_DATA_WRITE = 2'h1;
	localparam logic [1:0] INS_ADDR_READ  = 2'h2;
	localparam logic [1:0] INS_ADDR_WRITE = 2'h3;

	// Frame layout
	localparam logic [2:0] INS_LAST_BIT  = 3'h1;
	localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
	localparam logic [2:0] CNT_ZERO      = 3'h0;
	localparam logic [2:0] CNT_ONE       = 3'h1;

	typedef enum logic [3:0] {
		LINK_IDLE  = 4'h1,
		LINK_INS   = 4'h2,
		LINK_WDATA = 4'h4,
		LINK_RDATA = 4'h8
	} tfp_link_st_t;

	typedef enum logic [2:0] {
		UNL_LOCKED = 3'h1,
		UNL_FIRST  = 3'h2,
		UNL_OPEN   = 3'h4
	} tfp_unlock_st_t;

	typedef enum logic [2:0] {
		FCMD_BLOCK_READ   = 3'h1,
		FCMD_BLOCK_WRITE  = 3'h2,
		FCMD_PAGE_ERASE   = 3'h3,
		FCMD_DEVICE_ERASE = 3'h4,
		FCMD_NONE         = 3'h0
	} tfp_fcmd_t;

	// Request to the flash engine
	typedef struct packed {
		logic      valid;
		logic      is_cmd;
		tfp_fcmd_t cmd;
		logic [7:0] value;
	} tfp_flash_req_t;

	localparam tfp_flash_req_t REQ_IDLE = '{1'b0, 1'b0, FCMD_NONE, 8'h00};

endpackage

// ==== logic/tfp_link_regs.sv ====
// Two-wire debug link slave with flash programming registers
`timescale 1ns/10ps
module tfp_link_regs #(
	parameter logic [7:0] PART_ID  = 8'hA5, // Arbitrary value
	parameter logic [7:0] REVISION = 8'h5A  // Arbitrary value
) (
	input  wire logic                    SYS_CLK_I,
	input  wire logic                    RESETN_I,
	input  wire logic                    LINK_CLOCK_PIN_I,
	input  wire logic                    LINK_DATA_PIN_I,
	output logic                         LINK_DATA_PIN_O,
	output logic                         LINK_DATA_OE_O,
	output logic                         CORE_HALT_O,
	output logic                         PROG_ENABLE_O,
	output tfp_pkg::tfp_flash_req_t      FLASH_REQ_O,
	input  wire logic                    FLASH_DONE_I,
	input  wire logic                    FLASH_RDATA_VALID_I,
	input  wire logic [7:0]              FLASH_RDATA_I
);
	import tfp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; the link clock is sampled, not used as a clock
	logic       clk_s1_ff, clk_s2_ff, clk_prev_ff;
	logic       dat_s1_ff, dat_s2_ff;
	logic       link_rise, link_fall;

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			clk_s1_ff   <= 1'b0;
			clk_s2_ff   <= 1'b0;
			clk_prev_ff <= 1'b0;
			dat_s1_ff   <= 1'b0;
			dat_s2_ff   <= 1'b0;
		end
		else
		begin
			clk_s1_ff   <= LINK_CLOCK_PIN_I;
			clk_s2_ff   <= clk_s1_ff;
			clk_prev_ff <= clk_s2_ff;
			dat_s1_ff   <= LINK_DATA_PIN_I;
			dat_s2_ff   <= dat_s1_ff;
		end
	end

	assign link_rise = clk_s2_ff & ~clk_prev_ff;
	assign link_fall = ~clk_s2_ff & clk_prev_ff;

	////////////////////////////////////////////////////////////////////////
	// Register file state
	logic [7:0]     select_ff, nxt_select;
	logic [7:0]     control_ff, nxt_control;
	logic [7:0]     data_ff, nxt_data;
	tfp_unlock_st_t unl_ff, nxt_unl;
	logic           want_cmd_ff, nxt_want_cmd;
	tfp_flash_req_t req_ff, nxt_req;

	// Read mux for data reads
	function automatic logic [7:0] read_target(input logic [7:0] sel, input logic [7:0] ctl,
		input logic [7:0] dat);
		logic [7:0] r;
		r = 8'h00;
		if (sel == SEL_PART_ID || sel == SEL_PART_ID_LO)
			r = PART_ID;
		else if (sel == SEL_REVISION || sel == SEL_REVISION_LO)
			r = REVISION;
		else if (sel == SEL_CONTROL)
			r = ctl;
		else if (sel == SEL_DATA)
			r = dat;
		return r;
	endfunction

	function automatic tfp_fcmd_t decode_cmd(input logic [7:0] b);
		tfp_fcmd_t c;
		c = FCMD_NONE;
		if (b == CMD_BLOCK_READ)
			c = FCMD_BLOCK_READ;
		else if (b == CMD_BLOCK_WRITE)
			c = FCMD_BLOCK_WRITE;
		else if (b == CMD_PAGE_ERASE)
			c = FCMD_PAGE_ERASE;
		else if (b == CMD_DEVICE_ERASE)
			c = FCMD_DEVICE_ERASE;
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Link framing: start bit 1, two instruction bits, then eight data bits
	tfp_link_st_t lst_ff, nxt_lst;
	logic [2:0]   cnt_ff, nxt_cnt;
	logic [1:0]   ins_ff, nxt_ins;
	logic [7:0]   sh_ff, nxt_sh;
	logic         dout_ff, nxt_dout;
	logic         oe_ff, nxt_oe;
	logic         halt_ff, nxt_halt;
	logic         wr_ff, nxt_wr;

	always_comb
	begin
		nxt_lst  = lst_ff;
		nxt_cnt  = cnt_ff;
		nxt_ins  = ins_ff;
		nxt_sh   = sh_ff;
		nxt_dout = dout_ff;
		nxt_oe   = oe_ff;
		nxt_wr   = 1'b0;
		case (lst_ff)
			LINK_IDLE:
				if (link_rise && dat_s2_ff)
				begin
					nxt_lst = LINK_INS;
					nxt_cnt = CNT_ZERO;
				end
			LINK_INS:
				if (link_rise)
				begin
					nxt_ins = {dat_s2_ff, ins_ff[1]};
					nxt_cnt = cnt_ff + CNT_ONE;
					if (cnt_ff == INS_LAST_BIT)
					begin
						nxt_cnt = CNT_ZERO;
						if (ins_ff[1] == 1'b0) // First bit is the read/write flag
							nxt_lst = LINK_RDATA;
						else
							nxt_lst = LINK_WDATA;
						if (ins_ff[1] == 1'b0)
						begin
							if (dat_s2_ff)
								nxt_sh = select_ff;
							else
								nxt_sh = read_target(select_ff, control_ff, data_ff);
							nxt_dout = nxt_sh[0];
							nxt_sh   = {1'b0, nxt_sh[7:1]};
							nxt_oe   = 1'b1;
						end
					end
				end
			LINK_WDATA:
				if (link_rise)
				begin
					nxt_sh  = {dat_s2_ff, sh_ff[7:1]};
					nxt_cnt = cnt_ff + CNT_ONE;
					if (cnt_ff == BYTE_LAST_BIT)
					begin
						nxt_wr  = 1'b1;
						nxt_lst = LINK_IDLE;
					end
				end
			LINK_RDATA:
			begin
				if (link_fall && cnt_ff != CNT_ZERO)
				begin
					nxt_dout = sh_ff[0];
					nxt_sh   = {1'b0, sh_ff[7:1]};
				end
				if (link_rise)
				begin
					nxt_cnt = cnt_ff + CNT_ONE;
					if (cnt_ff == BYTE_LAST_BIT)
					begin
						nxt_oe  = 1'b0;
						nxt_lst = LINK_IDLE;
					end
				end
			end
			default:
				nxt_lst = LINK_IDLE;
		endcase
		// Halt stays asserted for the whole frame so user pins stay parked
		nxt_halt = (nxt_lst != LINK_IDLE);
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			lst_ff  <= LINK_IDLE;
			cnt_ff  <= CNT_ZERO;
			ins_ff  <= 2'h0;
			sh_ff   <= 8'h00;
			dout_ff <= 1'b0;
			oe_ff   <= 1'b0;
			halt_ff <= 1'b0;
			wr_ff   <= 1'b0;
		end
		else
		begin
			lst_ff  <= nxt_lst;
			cnt_ff  <= nxt_cnt;
			ins_ff  <= nxt_ins;
			sh_ff   <= nxt_sh;
			dout_ff <= nxt_dout;
			oe_ff   <= nxt_oe;
			halt_ff <= nxt_halt;
			wr_ff   <= nxt_wr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register writes, unlock sequence and flash requests
	always_comb
	begin
		nxt_select   = select_ff;
		nxt_control  = control_ff;
		nxt_data     = data_ff;
		nxt_unl      = unl_ff;
		nxt_want_cmd = want_cmd_ff;
		nxt_req      = REQ_IDLE;
		if (FLASH_RDATA_VALID_I)
			nxt_data = FLASH_RDATA_I;
		if (wr_ff && ins_ff[1])
			nxt_select = sh_ff;
		else if (wr_ff && select_ff == SEL_CONTROL)
		begin
			nxt_control = sh_ff;
			case (unl_ff)
				UNL_LOCKED:
					nxt_unl = (sh_ff == UNLOCK_FIRST) ? UNL_FIRST : UNL_LOCKED;
				UNL_FIRST:
					if (sh_ff == UNLOCK_SECOND)
						nxt_unl = UNL_OPEN;
					else if (sh_ff == UNLOCK_FIRST)
						nxt_unl = UNL_FIRST;
					else
						nxt_unl = UNL_LOCKED;
				UNL_OPEN:
					nxt_unl = UNL_OPEN;
				default:
					nxt_unl = UNL_LOCKED;
			endcase
		end
		else if (wr_ff && select_ff == SEL_DATA)
		begin
			nxt_data = sh_ff;
			// Unknown command codes are dropped so a stray byte cannot start work
			if (unl_ff == UNL_OPEN)
			begin
				if (want_cmd_ff)
				begin
					if (decode_cmd(sh_ff) != FCMD_NONE)
					begin
						nxt_req      = '{1'b1, 1'b1, decode_cmd(sh_ff), sh_ff};
						nxt_want_cmd = 1'b0;
					end
				end
				else
					nxt_req = '{1'b1, 1'b0, FCMD_NONE, sh_ff};
			end
		end
		// Engine done wins over a command taken in the same cycle
		if (FLASH_DONE_I)
			nxt_want_cmd = 1'b1;
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			select_ff   <= RST_SELECT;
			control_ff  <= RST_CONTROL;
			data_ff     <= RST_DATA;
			unl_ff      <= UNL_LOCKED;
			want_cmd_ff <= 1'b1;
			req_ff      <= REQ_IDLE;
		end
		else
		begin
			select_ff   <= nxt_select;
			control_ff  <= nxt_control;
			data_ff     <= nxt_data;
			unl_ff      <= nxt_unl;
			want_cmd_ff <= nxt_want_cmd;
			req_ff      <= nxt_req;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign LINK_DATA_PIN_O = dout_ff;
	assign LINK_DATA_OE_O  = oe_ff;
	assign CORE_HALT_O     = halt_ff;
	// One-hot open bit, so the output is a flop with no decode behind it
	assign PROG_ENABLE_O   = unl_ff[2];
	assign FLASH_REQ_O     = req_ff;

endmodule // tfp_link_regs

// ==== tb/tfp_link_regs_chk.sv ====
// Concurrent checks on the link register block ports
`timescale 1ns/10ps
module tfp_link_regs_chk (
	input wire logic             SYS_CLK_I,
	input wire logic             RESETN_I,
	input wire logic             LINK_DATA_OE_O,
	input wire logic             CORE_HALT_O,
	input wire logic             PROG_ENABLE_O,
	input tfp_pkg::tfp_flash_req_t FLASH_REQ_O
);
	import tfp_pkg::*;
	logic [7:0] halt_cnt_ff;
	// A frame is about 80 cycles, so a halt of twice that means a stuck frame
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
		if (!RESETN_I)
			halt_cnt_ff <= 8'h00;
		else
			halt_cnt_ff <= CORE_HALT_O ? halt_cnt_ff + 8'h01 : 8'h00;
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESETN_I);
	sequence s_en_hold; PROG_ENABLE_O ##1 PROG_ENABLE_O; endsequence
	sequence s_pulse; FLASH_REQ_O.valid ##1 !FLASH_REQ_O.valid; endsequence
	property p_oe_halt; $rose(LINK_DATA_OE_O) |-> CORE_HALT_O; endproperty
	property p_req_en; FLASH_REQ_O.valid |-> PROG_ENABLE_O; endproperty
	property p_en_sticky; PROG_ENABLE_O |-> s_en_hold; endproperty
	property p_req_pulse; FLASH_REQ_O.valid |-> s_pulse; endproperty
	property p_cmd_kind;
		FLASH_REQ_O.valid && FLASH_REQ_O.is_cmd |-> FLASH_REQ_O.cmd != FCMD_NONE;
	endproperty
	property p_param_none;
		FLASH_REQ_O.valid && !FLASH_REQ_O.is_cmd |-> FLASH_REQ_O.cmd == FCMD_NONE;
	endproperty
	property p_rst_clear;
		$rose(RESETN_I) |-> !PROG_ENABLE_O && !LINK_DATA_OE_O && !CORE_HALT_O;
	endproperty
	property p_halt_bound; halt_cnt_ff < 8'hA0; endproperty
	a_oe_halt: assert property (p_oe_halt)
		else $error("data pin driven while not halted");
	a_req_en: assert property (p_req_en)
		else $error("flash request while locked");
	a_en_sticky: assert property (p_en_sticky)
		else $error("programming enable dropped");
	a_req_pulse: assert property (p_req_pulse)
		else $error("flash request longer than one cycle");
	a_cmd_kind: assert property (p_cmd_kind)
		else $error("command request without a command");
	a_param_none: assert property (p_param_none)
		else $error("parameter request carries a command");
	a_rst_clear: assert property (p_rst_clear)
		else $error("outputs not cleared by reset");
	a_halt_bound: assert property (p_halt_bound)
		else $error("halt held too long");
endmodule // tfp_link_regs_chk

// ==== tb/tfp_host_model.sv ====
// Debug host model driving link clock and data pin
`timescale 1ns/10ps
module tfp_host_model (
	input  wire logic clk_i,
	input  wire logic pin_i,
	output logic      link_clk_o,
	output logic      link_dat_o
);
	initial
	begin
		link_clk_o = 1'b0;
		link_dat_o = 1'b0;
	end
	// Start, direction, target, then eight data bits LSB first
	task automatic frame(input logic tgt, input logic wr, input logic [7:0] wd,
		output logic [7:0] rd);
		logic [10:0] bits;
		bits = {wd, tgt, wr, 1'b1};
		rd = 8'h00;
		@(posedge clk_i);
		#2;
		for (int i = 0; i < 11; i++)
		begin
			// Released line toggles so a stale level never reads as data
			link_dat_o = (i < 3 || wr) ? bits[i] : ~link_dat_o;
			#80;
			if (i > 2)
				rd[i - 3] = pin_i;
			link_clk_o = 1'b1;
			#80;
			link_clk_o = 1'b0;
		end
		link_dat_o = 1'b0;
		#80;
	endtask
endmodule // tfp_host_model

// ==== tb/tb_tfp_link_regs.sv ====
// Testbench of the link register block
`timescale 1ns/10ps
module tb_tfp_link_regs;
	import tfp_pkg::*;
	localparam logic [7:0] PID = 8'h3C; // Arbitrary value
	localparam logic [7:0] REV = 8'hC3; // Arbitrary value
	logic clk = 1'b0, rst_n = 1'b0, done = 1'b0, rvld = 1'b0;
	logic lclk, hdat, dev_dat, dev_oe, halt, pen;
	logic [7:0] rdat = 8'h00, rd;
	tfp_flash_req_t req, last_req;
	int mismatches = 0, checks_done = 0, nreq = 0, cyc = 0;
	wire pin = dev_oe ? dev_dat : hdat;
	always #10 clk = ~clk;
	tfp_link_regs #(.PART_ID(PID), .REVISION(REV)) dut_u (.SYS_CLK_I(clk),
		.RESETN_I(rst_n), .LINK_CLOCK_PIN_I(lclk), .LINK_DATA_PIN_I(pin),
		.LINK_DATA_PIN_O(dev_dat), .LINK_DATA_OE_O(dev_oe), .CORE_HALT_O(halt),
		.PROG_ENABLE_O(pen), .FLASH_REQ_O(req), .FLASH_DONE_I(done),
		.FLASH_RDATA_VALID_I(rvld), .FLASH_RDATA_I(rdat));
	tfp_host_model hst_u (.clk_i(clk), .pin_i(pin), .link_clk_o(lclk), .link_dat_o(hdat));
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (req.valid === 1'b1)
		begin
			nreq++;
			last_req = req;
		end
		if (cyc == 20000)
		begin
			mismatches++;
			wrap_up();
		end
	end
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic tgt, input logic [7:0] v);
		hst_u.frame(tgt, 1'b1, v, rd);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		wr(1'b1, a);
		hst_u.frame(1'b0, 1'b0, 8'h00, rd);
		chk({5'h0, rd}, {5'h0, e});
	endtask
	task automatic pulse(ref logic s);
		@(posedge clk) #2 s = 1'b1;
		@(posedge clk) #2 s = 1'b0;
	endtask
	task automatic t_reset;
		chk({12'h0, halt}, 13'h0);
		fork
			hst_u.frame(1'b1, 1'b0, 8'h00, rd);
			begin
				#400;
				chk({12'h0, halt}, 13'h1);
			end
		join
		chk({12'h0, halt}, 13'h0);
		chk({5'h0, rd}, {5'h0, RST_SELECT});
		rchk(SEL_CONTROL, RST_CONTROL);
		rchk(SEL_DATA, RST_DATA);
	endtask
	task automatic t_ids;
		rchk(SEL_PART_ID, PID);
		rchk(SEL_REVISION, REV);
		wr(1'b0, 8'h33);
		rchk(SEL_REVISION, REV);
		rchk(SEL_PART_ID_LO, PID);
		rchk(SEL_REVISION_LO, REV);
	endtask
	task automatic t_lock;
		wr(1'b1, SEL_DATA);
		wr(1'b0, CMD_BLOCK_WRITE);
		chk(13'(nreq), 13'h0);
		wr(1'b1, SEL_CONTROL);
		wr(1'b0, UNLOCK_FIRST);
		wr(1'b0, 8'h05);
		wr(1'b0, UNLOCK_SECOND);
		chk({12'h0, pen}, 13'h0);
		wr(1'b0, UNLOCK_FIRST);
		wr(1'b0, UNLOCK_FIRST);
		wr(1'b0, UNLOCK_SECOND);
		chk({12'h0, pen}, 13'h1);
	endtask
	task automatic t_cmds;
		logic [7:0] code [4] = '{CMD_BLOCK_READ, CMD_BLOCK_WRITE, CMD_PAGE_ERASE,
			CMD_DEVICE_ERASE};
		tfp_fcmd_t kind [4] = '{FCMD_BLOCK_READ, FCMD_BLOCK_WRITE, FCMD_PAGE_ERASE,
			FCMD_DEVICE_ERASE};
		wr(1'b1, SEL_DATA);
		for (int i = 0; i < 4; i++)
		begin
			wr(1'b0, code[i]);
			chk({8'h0, last_req.is_cmd, 1'b0, last_req.cmd}, {8'h0, 2'b10, kind[i]});
			wr(1'b0, 8'h5C);
			chk(last_req, {2'b10, FCMD_NONE, 8'h5C});
			chk(13'(nreq), 13'(2 * i + 2));
			pulse(done);
		end
		wr(1'b0, 8'h0F);
		chk(13'(nreq), 13'h8);
		@(posedge clk) #2 rdat = 8'h9E;
		pulse(rvld);
		rchk(SEL_DATA, 8'h9E);
	endtask
	task automatic t_sticky;
		wr(1'b1, SEL_CONTROL);
		wr(1'b0, 8'h00);
		chk({12'h0, pen}, 13'h1);
		@(posedge clk) #2 rst_n = 1'b0;
		@(posedge clk) #2 rst_n = 1'b1;
		chk({12'h0, pen}, 13'h0);
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		#2 rst_n = 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_ids();
		t_lock();
		t_cmds();
		t_sticky();
		wrap_up();
	end
endmodule // tb_tfp_link_regs
bind tfp_link_regs tfp_link_regs_chk chk_u (.SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I),
	.LINK_DATA_OE_O(LINK_DATA_OE_O), .CORE_HALT_O(CORE_HALT_O),
	.PROG_ENABLE_O(PROG_ENABLE_O), .FLASH_REQ_O(FLASH_REQ_O));
